// >>> verilog/smpl_host.v
// Programmer host: drives supply modulation, decodes output replies, paces writes
// Function
// RL1 - Unlocked sensor powers up in programming mode
// RL2 - Volatile mode bit switches to application mode
// RL3 - Locked sensor runs application mode only
// RL4 - Programming mode lets telegrams alter registers
// RL5 - Programmer sends telegrams by supply modulation
// RL6 - Sensor replies on output; programmer decodes
// RL7 - Zero: no change inside bit time
// RL8 - One: change at half bit time
// RL9 - Level always toggles at bit end
// RL10 - Command bit time typically 1024 us
// RL11 - Answer bit time typically 1024 us
// RL12 - Telegrams carry memory, errors, field values
// RL13 - Wait 2 ms after memory write
// RL14 - Lock takes effect at next power-up
// RL15 - Read lock bit back to verify
// RL16 - Programmer sets lock after final programming
// RL17 - Receiver times edges against nominal bit period
`timescale 1ns/10ps
`include "smpl_regs.vh"
module smpl_host #(
   parameter BIT_CYCLES     = `SMPL_BIT_CYCLES,
   parameter PROG_CYCLES    = `SMPL_PROG_CYCLES,
   parameter POWERUP_CYCLES = `SMPL_POWERUP_CYCLES,
   parameter CNT_W          = `SMPL_CNT_W,
   parameter MAX_BITS       = `SMPL_MAX_BITS,
   parameter LEN_W          = `SMPL_LEN_W
) (
   input  wire                clk,
   input  wire                reset,
   input  wire                power_req,
   input  wire                cmd_valid,
   output wire                cmd_ready,
   input  wire [MAX_BITS-1:0] cmd_data,
   input  wire [LEN_W-1:0]    cmd_len,
   input  wire [LEN_W-1:0]    cmd_resp_len,
   input  wire                cmd_is_write,
   output reg                 resp_valid_reg,
   output reg  [MAX_BITS-1:0] resp_data_reg,
   output reg                 resp_error_reg,
   output reg                 supply_on_reg,
   output reg                 supply_high_reg,
   input  wire                sensor_out
);
   // Counts worked out as integers, then cut to the timer width; defaults fit in CNT_W bits
   localparam integer     HALF_I   = BIT_CYCLES / 2;
   localparam integer     FULL_I   = BIT_CYCLES;
   localparam integer     PROG_I   = PROG_CYCLES;
   localparam integer     PWR_I    = POWERUP_CYCLES;
   localparam integer     RESP_I   = BIT_CYCLES * 4;
   localparam [CNT_W-1:0] HALF_BIT = HALF_I[CNT_W-1:0];
   localparam [CNT_W-1:0] FULL_BIT = FULL_I[CNT_W-1:0];
   localparam [CNT_W-1:0] PROG_N   = PROG_I[CNT_W-1:0];
   localparam [CNT_W-1:0] PWR_N    = PWR_I[CNT_W-1:0];
   localparam [CNT_W-1:0] RESP_TO  = RESP_I[CNT_W-1:0];

   // One-hot states
   localparam [6:0] ST_OFF   = 7'h01;
   localparam [6:0] ST_PWRUP = 7'h02;
   localparam [6:0] ST_IDLE  = 7'h04;
   localparam [6:0] ST_SEND  = 7'h08;
   localparam [6:0] ST_RECV  = 7'h10;
   localparam [6:0] ST_PROG  = 7'h20;
   localparam [6:0] ST_DONE  = 7'h40;

   reg  [6:0]          state_reg;
   reg  [CNT_W-1:0]    cnt_reg;
   reg  [MAX_BITS-1:0] shift_reg;
   reg  [LEN_W-1:0]    bits_reg;
   reg  [LEN_W-1:0]    resp_len_reg;
   reg                 write_reg;
   reg                 err_reg;
   wire                rx_valid;
   wire                rx_value;
   wire                rx_timeout;
   wire                rx_enable;

   // Reply decoder only listens while a reply is expected [RL6]
   assign rx_enable = (state_reg == ST_RECV);
   assign cmd_ready = (state_reg == ST_IDLE);

   smpl_rx #(
      .BIT_CYCLES (BIT_CYCLES),
      .CNT_W      (CNT_W)
   ) u_rx (
      .clk           (clk),
      .reset         (reset),
      .enable        (rx_enable),
      .line_in       (sensor_out),
      .bit_valid_reg (rx_valid),
      .bit_value_reg (rx_value),
      .timeout_reg   (rx_timeout)
   );

   // Main sequencer: power, command send, reply collect, write wait
   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         state_reg       <= ST_OFF;
         cnt_reg         <= {CNT_W{1'b0}};
         shift_reg       <= {MAX_BITS{1'b0}};
         bits_reg        <= {LEN_W{1'b0}};
         resp_len_reg    <= {LEN_W{1'b0}};
         write_reg       <= 1'b0;
         err_reg         <= 1'b0;
         resp_valid_reg  <= 1'b0;
         resp_data_reg   <= {MAX_BITS{1'b0}};
         resp_error_reg  <= 1'b0;
         supply_on_reg   <= 1'b0;
         supply_high_reg <= 1'b0;
      end
      else
      begin
         resp_valid_reg <= 1'b0;
         if (!power_req && state_reg != ST_OFF)
         begin
            // Dropping power ends programming mode; a set lock acts at the next power-up [RL14]
            state_reg       <= ST_OFF;
            supply_on_reg   <= 1'b0;
            supply_high_reg <= 1'b0;
         end
         else
         begin
            case (state_reg)
               ST_OFF:
               begin
                  if (power_req)
                  begin
                     supply_on_reg <= 1'b1;
                     cnt_reg       <= {CNT_W{1'b0}};
                     state_reg     <= ST_PWRUP;
                  end
               end
               ST_PWRUP:
               begin
                  // Let the unlocked sensor settle into programming mode [RL1]
                  if (cnt_reg == PWR_N - 1'b1)
                     state_reg <= ST_IDLE;
                  else
                     cnt_reg <= cnt_reg + 1'b1;
               end
               ST_IDLE:
               begin
                  // Accept one telegram; lock, mode bit and writes all go this way [RL4] [RL12] [RL16]
                  if (cmd_valid && cmd_len != {LEN_W{1'b0}})
                  begin
                     shift_reg    <= cmd_data;
                     bits_reg     <= cmd_len;
                     resp_len_reg <= cmd_resp_len;
                     write_reg    <= cmd_is_write;
                     err_reg      <= 1'b0;
                     cnt_reg      <= {CNT_W{1'b0}};
                     state_reg    <= ST_SEND;
                     supply_high_reg <= ~supply_high_reg; // Opening change starts first bit
                  end
               end
               ST_SEND:
               begin
                  // MSB first; one mid change for a one, change at each end [RL5] [RL10]
                  if (cnt_reg == HALF_BIT && shift_reg[MAX_BITS-1])
                     supply_high_reg <= ~supply_high_reg; // [RL8]
                  if (cnt_reg == FULL_BIT - 1'b1)
                  begin
                     supply_high_reg <= ~supply_high_reg; // [RL9] [RL7]
                     cnt_reg   <= {CNT_W{1'b0}};
                     shift_reg <= {shift_reg[MAX_BITS-2:0], 1'b0};
                     bits_reg  <= bits_reg - 1'b1;
                     if (bits_reg == {{(LEN_W-1){1'b0}}, 1'b1})
                     begin
                        shift_reg <= {MAX_BITS{1'b0}};
                        bits_reg  <= resp_len_reg;
                        if (resp_len_reg != {LEN_W{1'b0}})
                           state_reg <= ST_RECV;
                        else if (write_reg)
                           state_reg <= ST_PROG;
                        else
                           state_reg <= ST_DONE;
                     end
                  end
                  else
                     cnt_reg <= cnt_reg + 1'b1;
               end
               ST_RECV:
               begin
                  // Collect answer bits, e.g. lock readback [RL11] [RL15]
                  if (rx_valid)
                  begin
                     shift_reg <= {shift_reg[MAX_BITS-2:0], rx_value};
                     bits_reg  <= bits_reg - 1'b1;
                     cnt_reg   <= {CNT_W{1'b0}};
                     if (bits_reg == {{(LEN_W-1){1'b0}}, 1'b1})
                        state_reg <= write_reg ? ST_PROG : ST_DONE;
                  end
                  else if (rx_timeout || cnt_reg == RESP_TO)
                  begin
                     // Missing answer; report and release the link
                     err_reg   <= 1'b1;
                     cnt_reg   <= {CNT_W{1'b0}};
                     state_reg <= write_reg ? ST_PROG : ST_DONE;
                  end
                  else
                     cnt_reg <= cnt_reg + 1'b1;
               end
               ST_PROG:
               begin
                  // Hold off further commands for the memory write time [RL13]
                  if (cnt_reg >= PROG_N - 1'b1)
                     state_reg <= ST_DONE;
                  else
                     cnt_reg <= cnt_reg + 1'b1;
               end
               ST_DONE:
               begin
                  resp_valid_reg <= 1'b1;
                  resp_data_reg  <= shift_reg;
                  resp_error_reg <= err_reg;
                  state_reg      <= ST_IDLE;
               end
               default:
                  state_reg <= ST_OFF;
            endcase
         end
      end
   end

   // Application mode (RL2, RL3) is the sensor's own concern; host only re-powers
endmodule // smpl_host

// >>> verilog/smpl_regs.vh
// Timing and coding constants for the supply-modulated programming link host
`ifndef SMPL_REGS_VH
`define SMPL_REGS_VH
`define SMPL_CLK_HZ          25000000
`define SMPL_BIT_TIME_US     1024
`define SMPL_BIT_CYCLES      ((`SMPL_BIT_TIME_US * (`SMPL_CLK_HZ / 1000000)))
`define SMPL_PROG_TIME_MS    2
`define SMPL_PROG_CYCLES     ((`SMPL_PROG_TIME_MS * (`SMPL_CLK_HZ / 1000)))
`define SMPL_TOL_PCT         25
`define SMPL_POWERUP_US      1000
`define SMPL_POWERUP_CYCLES  ((`SMPL_POWERUP_US * (`SMPL_CLK_HZ / 1000000)))
`define SMPL_CNT_W           20
`define SMPL_MAX_BITS        32
`define SMPL_LEN_W           6
`endif

// >>> verilog/smpl_rx.v
// Reply decoder: classifies answer bits from output-voltage level changes
`timescale 1ns/10ps
`include "smpl_regs.vh"
module smpl_rx #(
   parameter BIT_CYCLES = `SMPL_BIT_CYCLES,
   parameter CNT_W      = `SMPL_CNT_W
) (
   input  wire             clk,
   input  wire             reset,
   input  wire             enable,
   input  wire             line_in,
   output reg              bit_valid_reg,
   output reg              bit_value_reg,
   output reg              timeout_reg
);
   // Window edges worked out as integers, then cut to the timer width
   localparam integer     MID_LO_I = BIT_CYCLES / 4;
   localparam integer     MID_HI_I = (BIT_CYCLES * 3) / 4;
   localparam integer     END_LO_I = (BIT_CYCLES * 3) / 4 + 1;
   localparam integer     END_TO_I = (BIT_CYCLES * 3) / 2;
   localparam [CNT_W-1:0] MID_LO   = MID_LO_I[CNT_W-1:0];
   localparam [CNT_W-1:0] MID_HI   = MID_HI_I[CNT_W-1:0];
   localparam [CNT_W-1:0] END_LO   = END_LO_I[CNT_W-1:0];
   localparam [CNT_W-1:0] END_TO   = END_TO_I[CNT_W-1:0];

   reg  [2:0]       sync_reg;
   reg              last_reg;
   reg  [CNT_W-1:0] cnt_reg;
   reg              mid_reg;
   reg              started_reg;
   wire             level;
   wire             edge_seen;

   // Three-stage synchroniser; second and third must agree
   always @(posedge clk or posedge reset)
   begin
      if (reset)
         sync_reg <= 3'h0;
      else
         sync_reg <= {sync_reg[1:0], line_in};
   end

   assign level     = sync_reg[2];
   assign edge_seen = (sync_reg[1] == sync_reg[2]) && (sync_reg[2] != last_reg);

   // Timer from each boundary; a mid-window edge marks a one, a late edge closes the bit [RL17]
   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         last_reg      <= 1'b0;
         cnt_reg       <= {CNT_W{1'b0}};
         mid_reg       <= 1'b0;
         started_reg   <= 1'b0;
         bit_valid_reg <= 1'b0;
         bit_value_reg <= 1'b0;
         timeout_reg   <= 1'b0;
      end
      else
      begin
         bit_valid_reg <= 1'b0;
         timeout_reg   <= 1'b0;
         if (sync_reg[1] == sync_reg[2])
            last_reg <= level;
         if (!enable)
         begin
            started_reg <= 1'b0;
            cnt_reg     <= {CNT_W{1'b0}};
            mid_reg     <= 1'b0;
         end
         else if (edge_seen)
         begin
            if (!started_reg)
            begin
               // First level change opens the first bit period
               started_reg <= 1'b1;
               cnt_reg     <= {CNT_W{1'b0}};
               mid_reg     <= 1'b0;
            end
            else if (cnt_reg >= MID_LO && cnt_reg <= MID_HI && !mid_reg)
               mid_reg <= 1'b1; // [RL8]
            else if (cnt_reg >= END_LO)
            begin
               // Boundary change always present; mid change decides value [RL7] [RL9]
               bit_valid_reg <= 1'b1;
               bit_value_reg <= mid_reg;
               cnt_reg       <= {CNT_W{1'b0}};
               mid_reg       <= 1'b0;
            end
         end
         else if (started_reg)
         begin
            if (cnt_reg == END_TO)
            begin
               // No boundary change: reply ended or corrupted
               timeout_reg <= 1'b1;
               started_reg <= 1'b0;
               cnt_reg     <= {CNT_W{1'b0}};
            end
            else
               cnt_reg <= cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
         end
      end
   end
endmodule // smpl_rx

// >>> tb/smpl_host_chk.sv
// Checker for the programming-link host: timing and handshake relations at its ports
`timescale 1ns/10ps
module smpl_host_chk #(
   parameter BIT_CYCLES  = 64,
   parameter PROG_CYCLES = 100,
   parameter MAX_BITS    = 32,
   parameter LEN_W       = 6
) (
   input wire logic                clk,
   input wire logic                reset,
   input wire logic                power_req,
   input wire logic                cmd_valid,
   input wire logic                cmd_ready,
   input wire logic [MAX_BITS-1:0] cmd_data,
   input wire logic [LEN_W-1:0]    cmd_len,
   input wire logic [LEN_W-1:0]    cmd_resp_len,
   input wire logic                cmd_is_write,
   input wire logic                resp_valid_reg,
   input wire logic [MAX_BITS-1:0] resp_data_reg,
   input wire logic                resp_error_reg,
   input wire logic                supply_on_reg,
   input wire logic                supply_high_reg,
   input wire logic                sensor_out
);
   logic take, wr_reg, high_q;
   int   since_reg, gap_reg;
   assign take = cmd_ready && cmd_valid && cmd_len != '0;
   // Cycles since the last take and since the last supply level change
   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         since_reg <= 0;
         gap_reg   <= 0;
         wr_reg    <= 1'b0;
         high_q    <= 1'b0;
      end
      else
      begin
         since_reg <= take ? 0 : since_reg + 1;
         gap_reg   <= (supply_high_reg != high_q) ? 1 : gap_reg + 1;
         wr_reg    <= take ? cmd_is_write : wr_reg;
         high_q    <= supply_high_reg;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   a_ready_needs_power: assert property (cmd_ready |-> supply_on_reg)
      else $error("command ready while supply is off");
   a_powerup_settle: assert property ($rose(supply_on_reg) |-> !cmd_ready [*8])
      else $error("ready before supply settled");
   a_abort_cuts: assert property (!power_req |=> !supply_on_reg)
      else $error("supply kept after power request dropped");
   a_take_starts: assert property (take |=> $changed(supply_high_reg) && !cmd_ready)
      else $error("telegram start level change missing");
   // Start changes follow idle time, so only changes inside a telegram are measured
   a_half_spacing: assert property ($changed(supply_high_reg) && !$past(cmd_ready)
      && $past(supply_on_reg) && supply_on_reg |-> gap_reg >= BIT_CYCLES / 2 - 2)
      else $error("supply level changes closer than half a bit");
   a_write_wait: assert property (resp_valid_reg && wr_reg |-> since_reg >= BIT_CYCLES + PROG_CYCLES)
      else $error("write answered before programming time");
   a_valid_pulse: assert property (resp_valid_reg |=> !resp_valid_reg)
      else $error("answer strobe longer than one cycle");
   a_back_idle: assert property (resp_valid_reg && power_req |=> cmd_ready)
      else $error("not ready after answer");
   a_data_stands: assert property (!resp_valid_reg |-> $stable(resp_data_reg) && $stable(resp_error_reg))
      else $error("answer changed without strobe");
   c_write: cover property (take && cmd_is_write);
   c_answer_ok: cover property (resp_valid_reg && !resp_error_reg && cmd_resp_len != '0);
   c_answer_err: cover property (resp_valid_reg && resp_error_reg);
endmodule // smpl_host_chk
bind smpl_host smpl_host_chk #(.BIT_CYCLES(BIT_CYCLES), .PROG_CYCLES(PROG_CYCLES), .MAX_BITS(MAX_BITS),
   .LEN_W(LEN_W)) i_chk (.clk(clk), .reset(reset), .power_req(power_req), .cmd_valid(cmd_valid),
   .cmd_ready(cmd_ready), .cmd_data(cmd_data), .cmd_len(cmd_len), .cmd_resp_len(cmd_resp_len),
   .cmd_is_write(cmd_is_write), .resp_valid_reg(resp_valid_reg), .resp_data_reg(resp_data_reg),
   .resp_error_reg(resp_error_reg), .supply_on_reg(supply_on_reg), .supply_high_reg(supply_high_reg),
   .sensor_out(sensor_out));

// >>> tb/smpl_sensor_model.sv
// Behavioural sensor: decodes supply telegrams and answers on its output
`timescale 1ns/10ps
module smpl_sensor_model #(
   parameter BIT = 64
) (
   input  wire logic clk,
   input  wire logic supply_on,
   input  wire logic supply_high,
   output logic      sensor_out
);
   logic [7:0] rx;
   logic [3:0] reg_val;
   logic       lock_nv, app_mode, act, mid, last;
   int         bs;
   // Answer: start change, mid change for a one, change at every bit end
   task automatic answer(input logic [7:0] d);
      sensor_out <= ~sensor_out;
      for (int i = 7; i >= 0; i--)
      begin
         repeat (BIT / 2) @(posedge clk);
         if (d[i])
            sensor_out <= ~sensor_out;
         repeat (BIT / 2) @(posedge clk);
         sensor_out <= ~sensor_out;
      end
   endtask
   initial
   begin
      sensor_out = 1'b0;
      lock_nv    = 1'b0;
      reg_val    = 4'h0;
   end
   // Bits are classed by time since the last boundary change
   always @(posedge clk)
   begin
      last <= supply_high;
      bs   <= bs + 1;
      if (!supply_on)
      begin
         app_mode   <= lock_nv; // Lock acts from power-up only
         act        <= 1'b0;
         rx         <= 8'h00;
         sensor_out <= 1'b0; // Unpowered output sits low
      end
      else if (!app_mode && supply_high != last)
      begin
         if (act && !mid && bs < BIT * 3 / 4)
            mid <= 1'b1;
         else
         begin
            if (act)
               rx <= {rx[6:0], mid};
            act <= 1'b1;
            mid <= 1'b0;
            bs  <= 0;
         end
      end
      else if (act && bs == BIT * 5 / 4)
      begin
         act <= 1'b0;
         // Command set of this model
         case (rx[7:4])
            4'h3: reg_val <= rx[3:0];
            4'h4: answer({4'h0, reg_val});
            4'h5: lock_nv <= 1'b1;
            4'h6: answer({7'h00, lock_nv});
            4'h7: app_mode <= 1'b1;
            default: ;
         endcase
      end
   end
endmodule // smpl_sensor_model

// >>> tb/smpl_host_bench.sv
// Self-checking bench for the programming-link host against the sensor model
`timescale 1ns/10ps
module smpl_host_bench;
   localparam BIT = 64;
   localparam PROG = 100;
   logic        clk, reset, power_req, cmd_valid, cmd_is_write, sensor_out, cmd_ready;
   logic        resp_valid_reg, resp_error_reg, supply_on_reg, supply_high_reg;
   logic [31:0] cmd_data, resp_data_reg;
   logic [5:0]  cmd_len, cmd_resp_len;
   int          failures, num_checks, lat;
   smpl_host #(.BIT_CYCLES(BIT), .PROG_CYCLES(PROG), .POWERUP_CYCLES(10)) i_dut (.clk(clk), .reset(reset),
      .power_req(power_req), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_data(cmd_data), .cmd_len(cmd_len),
      .cmd_resp_len(cmd_resp_len), .cmd_is_write(cmd_is_write), .resp_valid_reg(resp_valid_reg),
      .resp_data_reg(resp_data_reg), .resp_error_reg(resp_error_reg), .supply_on_reg(supply_on_reg),
      .supply_high_reg(supply_high_reg), .sensor_out(sensor_out));
   smpl_sensor_model #(.BIT(BIT)) i_sensor (.clk(clk), .supply_on(supply_on_reg),
      .supply_high(supply_high_reg), .sensor_out(sensor_out));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Idle gap first so the sensor sees each telegram end, then a one-cycle request once ready
   task automatic send(input logic [7:0] d, input logic [5:0] rl, input logic wr);
      int n;
      n = 0;
      repeat (2 * BIT) @(negedge clk);
      while (cmd_ready !== 1'b1 && n < 5000)
      begin
         @(negedge clk);
         n++;
      end
      cmd_data = {d, 24'h000000};
      cmd_len = 6'h08;
      cmd_resp_len = rl;
      cmd_is_write = wr;
      cmd_valid = 1'b1;
      @(negedge clk);
      cmd_valid = 1'b0;
      lat = 1;
      while (resp_valid_reg !== 1'b1 && lat < 3000)
      begin
         @(negedge clk);
         lat++;
      end
      // A limit that runs out counts as a mismatch
      if (resp_valid_reg !== 1'b1 || n >= 5000)
         failures++;
   endtask
   task automatic power_cycle;
      power_req = 1'b0;
      repeat (8) @(negedge clk);
      power_req = 1'b1;
   endtask
   task automatic t_power_up;
      int n;
      n = 0;
      power_req = 1'b1;
      while (cmd_ready !== 1'b1 && n < 100)
      begin
         @(negedge clk);
         n++;
      end
      check(32'(n >= 10 && n <= 13), 32'h1);
   endtask
   task automatic t_write_reg;
      send(8'h3a, 6'h00, 1'b1);
      check({24'h0, i_sensor.rx}, 32'h3a);
      check(32'(lat >= 8 * BIT + PROG), 32'h1);
   endtask
   task automatic t_read_reg;
      send(8'h40, 6'h08, 1'b0);
      check(resp_data_reg, 32'h0000000a);
      check({31'h0, resp_error_reg}, 32'h0);
   endtask
   task automatic t_volatile;
      send(8'h70, 6'h00, 1'b0);
      send(8'h40, 6'h08, 1'b0);
      check({31'h0, resp_error_reg}, 32'h1);
      power_cycle();
      send(8'h40, 6'h08, 1'b0);
      check({31'h0, resp_error_reg}, 32'h0);
   endtask
   task automatic t_lock;
      send(8'h50, 6'h00, 1'b1);
      send(8'h60, 6'h08, 1'b0);
      check(resp_data_reg, 32'h00000001);
      check({31'h0, resp_error_reg}, 32'h0);
      power_cycle();
      send(8'h40, 6'h08, 1'b0);
      check({31'h0, resp_error_reg}, 32'h1);
   endtask
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial
   begin
      reset = 1'b1;
      power_req = 1'b0;
      cmd_valid = 1'b0;
      cmd_data = '0;
      cmd_len = '0;
      cmd_resp_len = '0;
      cmd_is_write = 1'b0;
      failures = 0;
      num_checks = 0;
      repeat (3) @(negedge clk);
      reset = 1'b0;
      t_power_up();
      t_write_reg();
      t_read_reg();
      t_volatile();
      t_lock();
      close_out();
   end
   // Watchdog: the sequence needs about 7700 cycles; margin for slow answers
   initial
   begin
      #(40 * 20000);
      failures++;
      close_out();
   end
endmodule // smpl_host_bench
